// ---- hdl/dual_port_ddr_sram_pins.sv ----
`timescale 1ns/1ps

// Operation
// - Each write word is taken on rising edges of both timing inputs.
// - A low write port select at a primary rise starts a write.
// - Four byte lane selects each guard one 9-bit lane of a word.
// - Lane selects are sampled with their word; unselected lanes stay.
// - One 19-bit address, sampled on a primary rise, serves both ports.
// - The address is ignored when the matching port select is high.
// - A low read port select at a primary rise starts a four-word read.
// - A running read finishes, then outputs float after a primary rise.
// - Read words launch on rising edges of both timing inputs.
// - The valid flag marks read data and moves with the echo clocks.
// - Accesses start, inputs are taken and data launch on primary rises.
// - The inverted rise is a second capture and launch point.
// - A free-running complementary echo clock pair follows the input.
// - With the bypass pin low, read latency drops to one cycle.

`include "dual_port_ddr_sram_map.svh"

module dual_port_ddr_sram_pins
   import sram_pins_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic k_in,
   input wire logic k_n_in,
   input wire logic write_port_sel_n_in,
   input wire logic read_port_sel_n_in,
   input wire logic [`ADDR_W-1:0] address_in,
   input wire logic [`DATA_W-1:0] write_data_in,
   input wire logic [`LANES-1:0] byte_lane_write_sel_n_in,
   input wire logic pll_bypass_n_in,
   output logic [`DATA_W-1:0] read_data_out,
   output logic read_data_oe_out,
   output logic output_valid_flag_out,
   output logic echo_timing_out,
   output logic echo_timing_n_out
);
   core_state_s s;
   core_state_s next_s;

   logic k_rise;
   logic kn_rise;
   logic any_edge;
   logic burst_free;
   logic launch;
   logic [`CNT_W-1:0] latency;
   rd_req_s req;
   rd_req_s head;
   logic [`REQ_W-1:0] head_bits;
   logic req_valid;
   logic head_valid;
   logic [`BEAT_W-1:0] beat_next;

   mem_port_if mp (
      .clk(core_clk_in)
   );

   sram_store u_store (
      .mp(mp.store)
   );

   // Read requests wait here until their launch edge comes round; a full
   // buffer refuses a new request rather than overwrite a pending one.
   two_entry_buffer #(
      .WIDTH(`REQ_W),
      .DEPTH(`BUF_DEPTH)
   ) u_req_buf (
      .clk_in(core_clk_in),
      .reset_in(reset_in),
      .in_valid_in(req_valid),
      .in_ready_out(),
      .in_data_in(req),
      .out_valid_out(head_valid),
      .out_ready_in(launch),
      .out_data_out(head_bits)
   );

   assign head = rd_req_s'(head_bits);

   function automatic logic [`MEM_AW-1:0] mem_index(
      input logic [`ADDR_W-1:0] addr,
      input logic [`BEAT_W-1:0] beat
   );
      mem_index = {addr, beat};
   endfunction : mem_index

   always_comb begin
      next_s = s;
      // Every pin passes two flops before use, so the timing edges and the
      // data they qualify stay aligned after the crossing.
      next_s.k_s1 = k_in;
      next_s.k_s2 = s.k_s1;
      next_s.k_prev = s.k_s2;
      next_s.kn_s1 = k_n_in;
      next_s.kn_s2 = s.kn_s1;
      next_s.kn_prev = s.kn_s2;
      next_s.wps_s1 = write_port_sel_n_in;
      next_s.wps_s2 = s.wps_s1;
      next_s.rps_s1 = read_port_sel_n_in;
      next_s.rps_s2 = s.rps_s1;
      next_s.pll_s1 = pll_bypass_n_in;
      next_s.pll_s2 = s.pll_s1;
      next_s.addr_s1 = address_in;
      next_s.addr_s2 = s.addr_s1;
      next_s.d_s1 = write_data_in;
      next_s.d_s2 = s.d_s1;
      next_s.bws_s1 = byte_lane_write_sel_n_in;
      next_s.bws_s2 = s.bws_s1;
      // The echo pair takes one more flop so that it leaves on the same
      // core edge as a read word, which needs a cycle for the fetch.
      next_s.echo = s.k_prev;
      next_s.echo_n = s.kn_prev;

      k_rise = s.k_s2 & ~s.k_prev;
      kn_rise = s.kn_s2 & ~s.kn_prev;
      any_edge = k_rise | kn_rise;
      next_s.edge_cnt = s.edge_cnt + `CNT_W'(any_edge);

      // Latency is counted in timing edges, half a primary cycle each.
      latency = s.pll_s2 ? `LAT_PLL : `LAT_BYPASS;

      req_valid = k_rise && !s.rps_s2;
      req.addr = s.addr_s2;
      req.due = next_s.edge_cnt + latency;

      mp.we = 1'b0;
      mp.waddr = mem_index(s.wr_addr, s.wr_beat);
      mp.wdata = s.d_s2;
      mp.lane_en = ~s.bws_s2;
      mp.re = 1'b0;
      mp.raddr = mem_index(s.rd_addr, s.rd_beat);

      case (s.wr_state)
         WR_IDLE: begin
            if (k_rise && !s.wps_s2) begin
               mp.we = 1'b1;
               mp.waddr = mem_index(s.addr_s2, `FIRST_BEAT);
               next_s.wr_addr = s.addr_s2;
               next_s.wr_beat = `FIRST_BEAT + 2'h1;
               next_s.wr_state = WR_BURST;
            end
         end
         WR_BURST: begin
            // Write select is not looked at mid-burst.
            if (any_edge) begin
               mp.we = 1'b1;
               next_s.wr_beat = s.wr_beat + 2'h1;
               if (s.wr_beat == `LAST_BEAT) begin
                  next_s.wr_state = WR_IDLE;
               end
            end
         end
         default: begin
            next_s.wr_state = WR_IDLE;
         end
      endcase

      // A fetched word reaches the pins one core cycle after its edge, the
      // same delay the echo clocks carry, so both stay aligned.
      // Burst ends are decided at the edge but reach the pins a cycle
      // later, like the words, so valid and the release stay on the echo.
      next_s.valid_off = 1'b0;
      next_s.oe_off = 1'b0;
      if (s.valid_off) begin
         next_s.valid = 1'b0;
      end
      if (s.oe_off) begin
         next_s.q_oe = 1'b0;
      end
      next_s.rd_fetch = 1'b0;
      if (s.rd_fetch) begin
         next_s.q = mp.rdata;
         next_s.q_oe = 1'b1;
         next_s.valid = 1'b1;
      end

      burst_free = (s.rd_state != RD_BURST) || (s.rd_beat == `LAST_BEAT);
      launch = any_edge && burst_free && head_valid &&
         (head.due == next_s.edge_cnt);
      beat_next = s.rd_beat + 2'h1;

      case (s.rd_state)
         RD_IDLE, RD_DRAIN: begin
            if (launch) begin
               next_s.rd_state = RD_BURST;
               next_s.rd_addr = head.addr;
               next_s.rd_beat = `FIRST_BEAT;
               mp.re = 1'b1;
               mp.raddr = mem_index(head.addr, `FIRST_BEAT);
               next_s.rd_fetch = 1'b1;
            end else if (s.rd_state == RD_DRAIN && k_rise) begin
               next_s.rd_state = RD_IDLE;
               next_s.oe_off = 1'b1;
            end
         end
         RD_BURST: begin
            if (launch) begin
               next_s.rd_addr = head.addr;
               next_s.rd_beat = `FIRST_BEAT;
               mp.re = 1'b1;
               mp.raddr = mem_index(head.addr, `FIRST_BEAT);
               next_s.rd_fetch = 1'b1;
            end else if (any_edge) begin
               if (s.rd_beat == `LAST_BEAT) begin
                  next_s.valid_off = 1'b1;
                  if (k_rise) begin
                     next_s.rd_state = RD_IDLE;
                     next_s.oe_off = 1'b1;
                  end else begin
                     next_s.rd_state = RD_DRAIN;
                  end
               end else begin
                  next_s.rd_beat = beat_next;
                  mp.re = 1'b1;
                  mp.raddr = mem_index(s.rd_addr, beat_next);
                  next_s.rd_fetch = 1'b1;
               end
            end
         end
         default: begin
            next_s.rd_state = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s <= '0;
         s.wr_state <= WR_IDLE;
         s.rd_state <= RD_IDLE;
         // High-resting pins start at their idle level, so that no false
         // edge or select is seen while the synchronisers fill.
         s.kn_s1 <= `PIN_IDLE;
         s.kn_s2 <= `PIN_IDLE;
         s.kn_prev <= `PIN_IDLE;
         s.echo_n <= `PIN_IDLE;
         s.wps_s1 <= `PIN_IDLE;
         s.wps_s2 <= `PIN_IDLE;
         s.rps_s1 <= `PIN_IDLE;
         s.rps_s2 <= `PIN_IDLE;
         s.pll_s1 <= `PIN_IDLE;
         s.pll_s2 <= `PIN_IDLE;
         s.bws_s1 <= {`LANES{`PIN_IDLE}};
         s.bws_s2 <= {`LANES{`PIN_IDLE}};
      end else begin
         s <= next_s;
      end
   end

   assign read_data_out = s.q;
   assign read_data_oe_out = s.q_oe;
   assign output_valid_flag_out = s.valid;
   // Echo clocks are the sampled timing inputs, so they run while the
   // inputs run and carry the same delay as the read data.
   assign echo_timing_out = s.echo;
   assign echo_timing_n_out = s.echo_n;
endmodule : dual_port_ddr_sram_pins

// ---- pkg/dual_port_ddr_sram_map.svh ----
`ifndef DUAL_PORT_DDR_SRAM_MAP_SVH
`define DUAL_PORT_DDR_SRAM_MAP_SVH

`define ADDR_W 19
`define DATA_W 36
`define LANE_W 9
`define LANES 4
`define BEAT_W 2
`define FIRST_BEAT 2'h0
`define LAST_BEAT 2'h3
`define MEM_AW 21
`define MEM_WORDS 2097152
`define CNT_W 8
`define LAT_PLL 8'h05
`define LAT_BYPASS 8'h02
`define REQ_W 27
`define BUF_DEPTH 2
`define PIN_IDLE 1'b1

`endif

// ---- pkg/sram_pins_pkg.sv ----
package sram_pins_pkg;
`include "dual_port_ddr_sram_map.svh"

   typedef enum logic [2:0] {
      RD_IDLE = 3'h1,
      RD_BURST = 3'h2,
      RD_DRAIN = 3'h4
   } rd_state_e;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h1,
      WR_BURST = 2'h2
   } wr_state_e;

   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [`CNT_W-1:0] due;
   } rd_req_s;

   typedef struct packed {
      logic k_s1;
      logic k_s2;
      logic k_prev;
      logic kn_s1;
      logic kn_s2;
      logic kn_prev;
      logic wps_s1;
      logic wps_s2;
      logic rps_s1;
      logic rps_s2;
      logic pll_s1;
      logic pll_s2;
      logic [`ADDR_W-1:0] addr_s1;
      logic [`ADDR_W-1:0] addr_s2;
      logic [`DATA_W-1:0] d_s1;
      logic [`DATA_W-1:0] d_s2;
      logic [`LANES-1:0] bws_s1;
      logic [`LANES-1:0] bws_s2;
      logic [`CNT_W-1:0] edge_cnt;
      wr_state_e wr_state;
      logic [`ADDR_W-1:0] wr_addr;
      logic [`BEAT_W-1:0] wr_beat;
      rd_state_e rd_state;
      logic [`ADDR_W-1:0] rd_addr;
      logic [`BEAT_W-1:0] rd_beat;
      logic rd_fetch;
      logic [`DATA_W-1:0] q;
      logic q_oe;
      logic valid;
      logic valid_off;
      logic oe_off;
      logic echo;
      logic echo_n;
   } core_state_s;

endpackage : sram_pins_pkg

// ---- pkg/mem_port_if.sv ----
`timescale 1ns/1ps
`include "dual_port_ddr_sram_map.svh"

interface mem_port_if (
   input wire logic clk
);
   logic we;
   logic [`MEM_AW-1:0] waddr;
   logic [`DATA_W-1:0] wdata;
   logic [`LANES-1:0] lane_en;
   logic re;
   logic [`MEM_AW-1:0] raddr;
   logic [`DATA_W-1:0] rdata;

   modport ctrl (
      output we,
      output waddr,
      output wdata,
      output lane_en,
      output re,
      output raddr,
      input rdata
   );

   modport store (
      input clk,
      input we,
      input waddr,
      input wdata,
      input lane_en,
      input re,
      input raddr,
      output rdata
   );
endinterface : mem_port_if

// ---- hdl/sram_store.sv ----
`timescale 1ns/1ps
`include "dual_port_ddr_sram_map.svh"

module sram_store
   import sram_pins_pkg::*;
(
   mem_port_if.store mp
);
   logic [`DATA_W-1:0] cells [0:`MEM_WORDS-1];

   // Lanes left unselected keep their old contents.
   always_ff @(posedge mp.clk) begin
      if (mp.we) begin
         for (int i = 0; i < `LANES; i++) begin
            if (mp.lane_en[i]) begin
               cells[mp.waddr][i*`LANE_W +: `LANE_W] <=
                  mp.wdata[i*`LANE_W +: `LANE_W];
            end
         end
      end
      if (mp.re) begin
         mp.rdata <= cells[mp.raddr];
      end
   end
endmodule : sram_store

// ---- hdl/two_entry_buffer.sv ----
`timescale 1ns/1ps
`include "dual_port_ddr_sram_map.svh"

module two_entry_buffer
   import sram_pins_pkg::*;
#(
   parameter int WIDTH = `REQ_W,
   parameter int DEPTH = `BUF_DEPTH
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } buf_s;

   buf_s s;
   buf_s next_s;
   logic push;
   logic pop;

   assign in_ready_out = s.count != 2'(DEPTH);
   assign out_valid_out = s.count != 2'h0;
   assign out_data_out = s.slot[s.rd_ptr];

   always_comb begin
      next_s = s;
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      if (push) begin
         next_s.slot[s.wr_ptr] = in_data_in;
         next_s.wr_ptr = ~s.wr_ptr;
      end
      if (pop) begin
         next_s.rd_ptr = ~s.rd_ptr;
      end
      next_s.count = s.count + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : two_entry_buffer

// ---- tb/sram_ctrl_model.sv ----
`timescale 1ns/1ps
`include "dual_port_ddr_sram_map.svh"
module sram_ctrl_model
   import sram_pins_pkg::*;
(
   input wire logic clk_in,
   output logic k_out,
   output logic k_n_out,
   output logic wps_n_out,
   output logic rps_n_out,
   output logic [`ADDR_W-1:0] addr_out,
   output logic [`DATA_W-1:0] data_out,
   output logic [`LANES-1:0] lanes_n_out
);
   // The timing pair runs free, eight core cycles a period.
   logic [2:0] phase = 3'h0;
   initial begin
      {k_out, k_n_out, wps_n_out, rps_n_out} = 4'h7;
      addr_out = '0;
      data_out = '0;
      lanes_n_out = 4'hF;
   end
   always @(posedge clk_in) begin
      phase <= phase + 3'h1;
      if (phase[1:0] == 2'h3) begin
         k_out <= phase[2];
         k_n_out <= !phase[2];
      end
   end
   // Words change only at the next edge, so each is held four core cycles.
   task automatic access(input logic wr, input logic rd,
         input logic [`ADDR_W-1:0] a, input logic [4*`DATA_W-1:0] w,
         input logic [4*`LANES-1:0] ln);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in iff phase == (i[0] ? 3'h3 : 3'h7));
         wps_n_out <= !(wr && i == 0);
         rps_n_out <= !(rd && i == 0);
         addr_out <= (i == 0) ? a : ~a;
         data_out <= w[i*`DATA_W +: `DATA_W];
         lanes_n_out <= ln[i*`LANES +: `LANES];
      end
   endtask : access
endmodule : sram_ctrl_model

// ---- tb/sram_pins_sva.sv ----
`timescale 1ns/1ps
`include "dual_port_ddr_sram_map.svh"
module sram_pins_sva
   import sram_pins_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic k_in,
   input wire logic read_port_sel_n_in,
   input wire logic pll_bypass_n_in,
   input wire logic [`DATA_W-1:0] read_data_out,
   input wire logic read_data_oe_out,
   input wire logic output_valid_flag_out,
   input wire logic echo_timing_out,
   input wire logic echo_timing_n_out
);
   // Cycle counts assume a link period of eight core cycles.
   default clocking dc @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   echo_follow_a: assert property (
      (!reset_in) [*5] |-> echo_timing_out == $past(k_in, 4))
      else $error("echo clock off k");
   echo_pair_a: assert property (
      (!reset_in) [*4] |-> echo_timing_n_out != echo_timing_out)
      else $error("echo pair not complementary");
   valid_edge_a: assert property (
      $changed(output_valid_flag_out) |-> $changed(echo_timing_out))
      else $error("valid moved off echo edge");
   data_launch_a: assert property (
      $changed(read_data_out) |-> $changed(echo_timing_out))
      else $error("read data moved off echo edge");
   valid_oe_a: assert property (
      output_valid_flag_out |-> read_data_oe_out)
      else $error("valid data on floating bus");
   oe_release_a: assert property (
      $fell(read_data_oe_out) |-> $rose(echo_timing_out))
      else $error("bus released off a k rise");
   burst_len_a: assert property (
      $rose(output_valid_flag_out) |->
      output_valid_flag_out [*8] ##8 output_valid_flag_out)
      else $error("read burst too short");
   byp_latency_a: assert property (
      $rose(k_in) && !read_port_sel_n_in && !pll_bypass_n_in &&
      !read_data_oe_out |-> ##12 $rose(output_valid_flag_out))
      else $error("bypass read latency wrong");
endmodule : sram_pins_sva

// ---- tb/tb_dual_port_ddr_sram_pins.sv ----
`timescale 1ns/1ps
`include "dual_port_ddr_sram_map.svh"
module tb_dual_port_ddr_sram_pins
   import sram_pins_pkg::*;
;
   localparam logic [`ADDR_W-1:0] A_TOP = 19'h7FFFF;
   localparam logic [`ADDR_W-1:0] A_LOW = 19'h00000;
   localparam logic [4*`DATA_W-1:0] JUNK = {4{36'h5A5A5A5A5}};
   localparam logic [4*`DATA_W-1:0] W_MIX = {36'h444444444,
      36'h333333333, 36'h222222222, 36'h111111111};
   logic core_clk_in;
   logic reset_in;
   logic pll_bypass_n;
   logic k, k_n, wps_n, rps_n, oe, valid, echo, echo_n;
   logic [`ADDR_W-1:0] addr;
   logic [`DATA_W-1:0] wdata, rdata;
   logic [`LANES-1:0] lanes_n;
   logic [`DATA_W-1:0] ref_mem [logic [`MEM_AW-1:0]];
   int failures, samples_checked, cycles;

   sram_ctrl_model m (.clk_in(core_clk_in), .k_out(k), .k_n_out(k_n),
      .wps_n_out(wps_n), .rps_n_out(rps_n), .addr_out(addr),
      .data_out(wdata), .lanes_n_out(lanes_n));
   dual_port_ddr_sram_pins uut (.core_clk_in(core_clk_in),
      .reset_in(reset_in), .k_in(k), .k_n_in(k_n),
      .write_port_sel_n_in(wps_n), .read_port_sel_n_in(rps_n),
      .address_in(addr), .write_data_in(wdata),
      .byte_lane_write_sel_n_in(lanes_n), .pll_bypass_n_in(pll_bypass_n),
      .read_data_out(rdata), .read_data_oe_out(oe),
      .output_valid_flag_out(valid), .echo_timing_out(echo),
      .echo_timing_n_out(echo_n));

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask : check

   task automatic note_write(input logic [`ADDR_W-1:0] a,
         input logic [4*`DATA_W-1:0] w, input logic [4*`LANES-1:0] ln);
      for (int n = 0; n < 4; n++) begin
         for (int i = 0; i < 4; i++) begin
            if (!ln[n*4+i]) begin
               ref_mem[{a, 2'(n)}][i*9 +: 9] = w[n*36+i*9 +: 9];
            end
         end
      end
   endtask : note_write

   task automatic do_write(input logic [`ADDR_W-1:0] a,
         input logic [4*`DATA_W-1:0] w, input logic [4*`LANES-1:0] ln);
      note_write(a, w, ln);
      m.access(1'b1, 1'b0, a, w, ln);
   endtask : do_write

   // Latency is timed from the first core cycle that shows the request.
   task automatic capture(input logic [`ADDR_W-1:0] a, input int lat);
      int t;
      t = 0;
      while (lat > 0 && rps_n !== 1'b0) @(negedge core_clk_in);
      while (valid !== 1'b1 && t < 40) begin
         @(negedge core_clk_in);
         t++;
      end
      if (lat > 0) check(t == lat, "read latency");
      for (int n = 0; n < 4; n++) begin
         check(valid === 1'b1 && oe === 1'b1 &&
            rdata === ref_mem[{a, 2'(n)}], "read word");
         repeat (4) @(negedge core_clk_in);
      end
   endtask : capture

   task automatic do_read(input logic [`ADDR_W-1:0] a, input int lat,
         input int bursts, input logic wr = 1'b0,
         input logic [4*`DATA_W-1:0] w = JUNK);
      fork
         for (int b = 0; b < bursts; b++) begin
            m.access(wr && b == 0, 1'b1, a, w, '0);
         end
         for (int b = 0; b < bursts; b++) capture(a, b == 0 ? lat : 0);
      join
      check(valid === 1'b0, "valid after burst");
      repeat (4) @(negedge core_clk_in);
      check(oe === 1'b0, "bus not released");
   endtask : do_read

   task automatic t_full();
      do_write(A_TOP, {36'hC0C0C0C03, 36'hB0B0B0B02, 36'hA0A0A0A01,
         36'h9F9F9F9F0}, 16'h0000);
      do_read(A_TOP, 24, 1);
   endtask : t_full

   task automatic t_lanes();
      do_write(A_TOP, {4{36'h123456789}}, 16'h8421);
      do_read(A_TOP, 24, 1);
   endtask : t_lanes

   task automatic t_deselect();
      m.access(1'b0, 1'b0, A_TOP, JUNK, 16'h0000);
      do_read(A_TOP, 24, 1);
   endtask : t_deselect

   task automatic t_back_to_back();
      do_write(A_LOW, {4{36'hFEDCBA987}}, 16'h0000);
      do_read(A_LOW, 24, 2);
   endtask : t_back_to_back

   // Write and read start on one primary rise; the read sees the new words.
   task automatic t_concurrent();
      note_write(A_LOW, W_MIX, 16'h0000);
      do_read(A_LOW, 24, 1, 1'b1, W_MIX);
   endtask : t_concurrent

   task automatic t_bypass();
      @(posedge core_clk_in);
      pll_bypass_n <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      do_read(A_LOW, 12, 1);
      @(posedge core_clk_in);
      pll_bypass_n <= 1'b1;
   endtask : t_bypass

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         $display("[ERR] %0t run timed out", $time);
         stop_test();
      end
   end

   initial begin
      reset_in = 1'b1;
      pll_bypass_n = 1'b1;
      repeat (2) @(posedge core_clk_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      t_full();
      t_lanes();
      t_deselect();
      t_back_to_back();
      t_concurrent();
      t_bypass();
      stop_test();
   end
endmodule : tb_dual_port_ddr_sram_pins

bind dual_port_ddr_sram_pins sram_pins_sva chk (.core_clk_in, .reset_in,
   .k_in, .read_port_sel_n_in, .pll_bypass_n_in, .read_data_out,
   .read_data_oe_out, .output_valid_flag_out, .echo_timing_out,
   .echo_timing_n_out);
